// >>> logic/edt_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; writer and reader are on the same domain
`timescale 1ns/100ps
`default_nettype none
module edt_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] LAST_C = (PW)'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];   // storage
   logic [PW-1:0] wptr_r;             // next write slot
   logic [PW-1:0] rptr_r;             // oldest word
   logic [PW:0] count_r;              // words held
   logic push;
   logic pop;

   // full and empty come from the count, so they never lie
   assign in_ready_o = (count_r != DEPTH_C);
   assign out_valid_o = (count_r != '0);
   assign out_data_o = mem_r[rptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage has no reset; reads are gated by the count
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wptr_r] <= in_data_i;
      end
   end

   // pointers wrap explicitly so non power of two depths work
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= (wptr_r == LAST_C) ? '0 : wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r <= (rptr_r == LAST_C) ? '0 : rptr_r + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
      end
   end
endmodule // edt_fifo
`default_nettype wire

// >>> logic/edt_pkg.sv
// constants shared by the edge time stamp input block and its fifo
// assumes one 50 MHz clock and a synchronous active-high reset
// Functional notes
// - each enabled edge records stamp, inputs, sequence
// - rising, falling or both selectable per input
// - small variant: 20 bytes, five entries
// - large variant: 60 bytes, fifteen entries
// - entry k starts at byte 4k
// - byte0 inputs, byte1 sequence, bytes2-3 stamp
// - entries filled in edge order, one after another
// - input byte shows levels after the edge
// - bit0 first, bit1 second, bits 2-7 zero
// - sequence 0..127, first entry numbered 1
// - 32-bit microsecond timer from zero at reset
// - timer wraps to zero after maximum
// - stored stamp is timer low 16 bits
// - output image bytes are ignored
// - one indicator per input shows its level
package edt_pkg;
   // clock and timer
   localparam int CLK_PERIOD_NS = 20;                   // 50 MHz
   localparam int US_PERIOD_NS = 1000;                  // one microsecond
   localparam int US_CYCLES = US_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 32;
   localparam int STAMP_W = 16;
   // channels and image layout
   localparam int NUM_CH = 2;
   localparam int ENTRY_BYTES = 4;
   localparam int SMALL_ENTRIES = 5;
   localparam int LARGE_ENTRIES = 15;
   localparam int SMALL_BYTES = 20;
   localparam int LARGE_BYTES = 60;
   localparam int ADDR_W = 6;
   localparam int SLOT_W = 4;
   // byte offsets inside one entry
   localparam logic [1:0] OFS_INPUT_STATE = 2'h0;       // entry_input_state
   localparam logic [1:0] OFS_SEQUENCE = 2'h1;          // entry_sequence_number
   localparam logic [1:0] OFS_STAMP_LO = 2'h2;          // entry_time_low, low byte
   localparam logic [1:0] OFS_STAMP_HI = 2'h3;          // entry_time_low, high byte
   // sequence counter
   localparam logic [6:0] SEQ_MAX = 7'h7f;
   localparam logic [6:0] SEQ_RESET = 7'h00;
   // fifo in the capture path
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = NUM_CH + STAMP_W;
   // reset values
   localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0000_0000;
   localparam logic [SLOT_W-1:0] SLOT_RESET = 4'h0;
   localparam logic [5:0] DIV_RESET = 6'h00;
endpackage

// >>> logic/edt_top.sv
// edge time stamp input: two synchronised inputs, microsecond timer,
// capture fifo and the entry image read by the backplane side
// assumes the image reader uses clk_i and only changes the variant
// while the stop input is high
`timescale 1ns/100ps
`default_nettype none
module edt_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // field inputs, asynchronous
   input wire logic first_input_i,
   input wire logic second_input_i,
   // configuration, bit n belongs to input n
   input wire logic [edt_pkg::NUM_CH-1:0] rise_en_i,
   input wire logic [edt_pkg::NUM_CH-1:0] fall_en_i,
   input wire logic large_variant_i,
   input wire logic system_stop_i,
   // input image read port
   input wire logic img_rd_en_i,
   input wire logic [edt_pkg::ADDR_W-1:0] img_addr_i,
   output logic [7:0] img_rd_data_o,
   output logic img_rd_valid_o,
   // output image write port, unused by this block
   input wire logic out_wr_en_i,
   input wire logic [7:0] out_wr_data_i,
   // status
   output logic first_input_led_o,
   output logic second_input_led_o,
   output logic capture_ready_o,
   output logic event_lost_o,
   output logic large_active_o
);
   import edt_pkg::*;

   // derived limits, sized to the registers they are compared with so no
   // comparison silently widens or truncates
   localparam logic [5:0] DIV_LAST = 6'(US_CYCLES - 1);
   localparam logic [SLOT_W-1:0] SMALL_LAST = 4'(SMALL_ENTRIES - 1);
   localparam logic [SLOT_W-1:0] LARGE_LAST = 4'(LARGE_ENTRIES - 1);
   localparam logic [ADDR_W-1:0] SMALL_END = 6'(SMALL_BYTES);
   localparam logic [ADDR_W-1:0] LARGE_END = 6'(LARGE_BYTES);

   // pin synchronisers and debounced levels
   logic [NUM_CH-1:0] pin_in;       // raw pins as a vector
   logic [NUM_CH-1:0] sync1_r;      // first stage, read only by sync2
   logic [NUM_CH-1:0] sync2_r;
   logic [NUM_CH-1:0] sync3_r;
   logic [NUM_CH-1:0] level_r;      // accepted level per input
   logic [NUM_CH-1:0] level_nxt;
   logic [NUM_CH-1:0] rise_evt;     // accepted rising change
   logic [NUM_CH-1:0] fall_evt;     // accepted falling change
   logic capture;                   // an enabled edge this cycle

   // timer
   logic [5:0] div_r;               // microsecond divider
   logic us_tick;                   // one-cycle enable per microsecond
   logic [TIMER_W-1:0] timer_r;     // free running microseconds

   // fifo between capture and image writer
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [FIFO_W-1:0] fifo_in_data;
   logic [FIFO_W-1:0] fifo_out_data;

   // image writer
   logic large_r;                   // active variant
   logic [SLOT_W-1:0] slot_r;       // next entry slot
   logic [SLOT_W-1:0] slot_last;
   logic [6:0] seq_r;               // last number handed out
   logic [6:0] seq_nxt;
   logic wr_entry;
   logic [31:0] image_r [LARGE_ENTRIES];      // entry words
   logic [LARGE_ENTRIES-1:0] written_r;       // slot holds an entry

   // read path
   logic [ADDR_W-1:0] rd_end;
   logic [SLOT_W-1:0] rd_slot;
   logic [1:0] rd_byte;
   logic [31:0] rd_word;
   logic rd_hit;

   assign pin_in = {second_input_i, first_input_i};

   // per input: three stage synchroniser, level accepted when the
   // second and third stages agree, then edge classification
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sync1_r[ch] <= 1'b0;
               sync2_r[ch] <= 1'b0;
               sync3_r[ch] <= 1'b0;
            end else begin
               sync1_r[ch] <= pin_in[ch];
               sync2_r[ch] <= sync1_r[ch];
               sync3_r[ch] <= sync2_r[ch];
            end
         end
         // a change counts only once two stages agree on it
         assign level_nxt[ch] = (sync2_r[ch] == sync3_r[ch]) ? sync3_r[ch] : level_r[ch];
         assign rise_evt[ch] = level_nxt[ch] && !level_r[ch];
         assign fall_evt[ch] = !level_nxt[ch] && level_r[ch];
      end
   endgenerate

   // accepted levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_r <= '0;
      end else begin
         level_r <= level_nxt;
      end
   end

   // any enabled polarity on any input starts one entry; simultaneous
   // edges on both inputs share one entry
   // the stored levels after the edge still show which inputs changed
   assign capture = |((rise_evt & rise_en_i) | (fall_evt & fall_en_i));

   // microsecond divider, a one-cycle enable every US_CYCLES clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= DIV_RESET;
      end else if (div_r == DIV_LAST) begin
         div_r <= DIV_RESET;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign us_tick = (div_r == DIV_LAST);

   // timer starts at zero out of reset and wraps by natural overflow
   // only the low half reaches the image, so a host must unwrap the
   // stamp itself when edges lie more than 65535 us apart
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_r <= TIMER_RESET;
      end else if (us_tick) begin
         timer_r <= timer_r + 1'b1;
      end
   end

   // capture word: levels after the edge plus timer low half; the fifo
   // absorbs bursts while the reader holds the image port
   assign fifo_in_data = {level_nxt, timer_r[STAMP_W-1:0]};

   edt_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(capture),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // writer yields to the reader so a read never sees a half update
   // trade-off: a reader that strobes every cycle starves the writer; the
   // fifo then fills and further edges are counted as lost
   assign fifo_out_ready = !img_rd_en_i;
   assign wr_entry = fifo_out_valid && fifo_out_ready;

   // variant is taken only while the system is stopped
   // a change while running is ignored until the next stop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         large_r <= 1'b0;
      end else if (system_stop_i) begin
         large_r <= large_variant_i;
      end
   end
   assign slot_last = large_r ? LARGE_LAST : SMALL_LAST;

   // slot pointer fills entries in edge order and wraps to slot zero;
   // a variant switch that leaves the slot outside the region restarts
   // at slot zero, but an entry written in the first cycle after the switch still lands outside the active region
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot_r <= SLOT_RESET;
      end else if (wr_entry) begin
         slot_r <= (slot_r >= slot_last) ? SLOT_RESET : slot_r + 1'b1;
      end else if (slot_r > slot_last) begin
         slot_r <= SLOT_RESET;
      end
   end

   // sequence: reset value zero so the first entry carries one
   // the number has seven bits; bit 7 of the stored byte stays zero
   assign seq_nxt = (seq_r == SEQ_MAX) ? 7'h00 : seq_r + 1'b1;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_r <= SEQ_RESET;
      end else if (wr_entry) begin
         seq_r <= seq_nxt;
      end
   end

   // entry word, byte n at bits 8n+7:8n; stamp low byte at +2
   always_ff @(posedge clk_i) begin
      if (wr_entry) begin
         image_r[slot_r] <= {fifo_out_data[STAMP_W-1:0], 1'b0, seq_nxt,
                             6'h00, fifo_out_data[FIFO_W-1:STAMP_W]};
      end
   end

   // slot occupancy, cleared only by reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         written_r <= '0;
      end else if (wr_entry) begin
         written_r[slot_r] <= 1'b1;
      end
   end

   // read decode: byte address 4k+n selects byte n of entry k
   // slot index 15 lies past the largest region; the range test masks it
   // before the occupancy bit is used
   assign rd_end = large_r ? LARGE_END : SMALL_END;
   assign rd_slot = img_addr_i[ADDR_W-1:2];
   assign rd_byte = img_addr_i[1:0];
   assign rd_hit = (img_addr_i < rd_end) && written_r[rd_slot];
   assign rd_word = rd_hit ? image_r[rd_slot] : 32'h0000_0000;

   // registered read data; outside the region and empty slots read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         img_rd_data_o <= 8'h00;
      end else if (img_rd_en_i) begin
         unique case (rd_byte)
            OFS_INPUT_STATE: img_rd_data_o <= rd_word[7:0];
            OFS_SEQUENCE: img_rd_data_o <= rd_word[15:8];
            OFS_STAMP_LO: img_rd_data_o <= rd_word[23:16];
            OFS_STAMP_HI: img_rd_data_o <= rd_word[31:24];
         endcase
      end
   end

   // read strobe answer one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         img_rd_valid_o <= 1'b0;
      end else begin
         img_rd_valid_o <= img_rd_en_i;
      end
   end

   // the output image is accepted and dropped; nothing here stores it
   logic out_unused;
   assign out_unused = out_wr_en_i ^ (^out_wr_data_i);

   // indicators follow the accepted levels
   // they share the synchroniser, so a lamp never disagrees with level_r; the image holds only levels from enabled edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_input_led_o <= 1'b0;
         second_input_led_o <= 1'b0;
      end else begin
         first_input_led_o <= level_nxt[0];
         second_input_led_o <= level_nxt[1];
      end
   end

   // status: fifo fill ready, sticky loss when an edge met a full fifo
   // loss stays set until reset so a host polling slowly still sees it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_ready_o <= 1'b0;
         event_lost_o <= 1'b0;
         large_active_o <= 1'b0;
      end else begin
         capture_ready_o <= fifo_in_ready;
         event_lost_o <= event_lost_o || (capture && !fifo_in_ready);
         large_active_o <= large_r;
      end
   end

   // checks
   // helper flops remember what the previous read asked for, so the
   // registered answer can be judged one cycle later
   logic [1:0] rd_byte_q;
   logic rd_out_q;
   always_ff @(posedge clk_i) begin
      rd_byte_q <= rd_byte;
      rd_out_q <= img_rd_en_i && !(img_addr_i < rd_end);
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // timer
   AST_TIMER_STEP: assert property (us_tick
      |=> timer_r == $past(timer_r) + 32'h0000_0001)
      else $error("timer did not step on tick");
   AST_TIMER_HOLD: assert property (!us_tick
      |=> $stable(timer_r))
      else $error("timer moved without tick");
   AST_TICK_GAP: assert property (us_tick
      |=> !us_tick [*8])
      else $error("ticks too close");

   // sequence, slot and stored entry
   AST_SEQ_FIRST: assert property (wr_entry && seq_r == 7'h00
      |=> seq_r == 7'h01)
      else $error("sequence did not start at one");
   AST_SEQ_WRAP: assert property (wr_entry && seq_r == SEQ_MAX
      |=> seq_r == 7'h00)
      else $error("sequence did not wrap");
   AST_SLOT_NEXT: assert property (wr_entry && slot_r < slot_last
      |=> slot_r == $past(slot_r) + 4'h1)
      else $error("slot did not advance");
   AST_SLOT_WRAP: assert property (wr_entry && slot_r == slot_last
      |=> slot_r == 4'h0)
      else $error("slot did not wrap");
   AST_IMG_RSVD: assert property (wr_entry
      |=> image_r[$past(slot_r)][7:2] == 6'h00 && !image_r[$past(slot_r)][15])
      else $error("stored entry has reserved bits set");

   // read path
   AST_RD_ANSWER: assert property (img_rd_en_i
      |=> img_rd_valid_o)
      else $error("read strobe not answered");
   AST_RSVD_ZERO: assert property (img_rd_valid_o && rd_byte_q == OFS_INPUT_STATE
      |-> img_rd_data_o[7:2] == 6'h00)
      else $error("reserved input bits set");
   AST_OUT_RANGE: assert property (rd_out_q
      |-> img_rd_data_o == 8'h00)
      else $error("read past region not zero");

   // capture and indicators
   AST_EDGE_PUSH: assert property (capture && fifo_in_ready
      |=> fifo_out_valid)
      else $error("edge not queued");
   AST_LED_LEVEL: assert property (sync2_r[0] == sync3_r[0]
      |=> first_input_led_o == $past(sync3_r[0]))
      else $error("indicator does not follow input");

   COV_WRITE: cover property (wr_entry);
   COV_SEQ_WRAP: cover property (wr_entry && seq_r == SEQ_MAX);
   COV_LARGE_WRAP: cover property (wr_entry && large_r && slot_r == LARGE_LAST);
   COV_BOTH_EDGES: cover property (capture && &(rise_evt | fall_evt));
   COV_LOST: cover property (capture && !fifo_in_ready);
endmodule // edt_top
`default_nettype wire

// >>> sim/edt_reader.sv
// image reader model: the backplane side that fetches bytes of the input image
// assumes clk_i is the block clock; requests change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module edt_reader (
   // clock
   input wire logic clk_i,
   // answer from the block
   input wire logic [7:0] img_rd_data_i,
   input wire logic img_rd_valid_i,
   // request to the block
   output logic img_rd_en_o,
   output logic [edt_pkg::ADDR_W-1:0] img_addr_o
);
   import edt_pkg::*;
   // idle bus starts quiet
   initial begin
      img_rd_en_o = 1'b0;
      img_addr_o = 6'h00;
   end
   // one strobe, then wait a bounded time for the answer
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
      int i;
      @(negedge clk_i);
      img_rd_en_o = 1'b1;
      img_addr_o = a;
      @(negedge clk_i);
      img_rd_en_o = 1'b0;
      img_addr_o = ~a; // idle address is garbage, never a stale copy
      ok = 1'b0;
      d = 8'h00;
      for (i = 0; i < 4; i++) begin
         if (!ok && img_rd_valid_i === 1'b1) begin
            d = img_rd_data_i;
            ok = 1'b1;
         end
         if (!ok) @(negedge clk_i);
      end
   endtask
   // back-to-back reads hold the strobe; the writer stalls meanwhile
   task automatic burst(input int n);
      @(negedge clk_i);
      img_rd_en_o = 1'b1;
      repeat (n) begin
         @(negedge clk_i);
         img_addr_o = img_addr_o + 6'h01; // address walks every cycle
      end
      img_rd_en_o = 1'b0;
   endtask
endmodule // edt_reader
`default_nettype wire

// >>> sim/tb_edt_top.sv
// testbench for the edge time stamp input block
// assumes edt_pkg, edt_fifo and edt_top are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_edt_top;
   import edt_pkg::*;
   // stimulus, all given values at time zero
   logic clk_i = 1'b0, rst_i = 1'b1, first_input_i = 1'b0, second_input_i = 1'b0;
   logic large_variant_i = 1'b0, system_stop_i = 1'b0, out_wr_en_i = 1'b0;
   logic [NUM_CH-1:0] rise_en_i = 2'h0, fall_en_i = 2'h0;
   logic [7:0] out_wr_data_i = 8'h00;
   // observed
   logic img_rd_en_i, img_rd_valid_o, first_input_led_o, second_input_led_o;
   logic capture_ready_o, event_lost_o, large_active_o;
   logic [ADDR_W-1:0] img_addr_i;
   logic [7:0] img_rd_data_o;
   // expected image and bookkeeping
   logic [7:0] img_m [0:LARGE_BYTES-1];
   int errors = 0, n_checks = 0, cyc = 0, seq_m = 0, slot_m = 0, nent = SMALL_ENTRIES;
   // clock at 50 MHz
   initial begin
      forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
   end
   // cycle count since reset, used to predict the microsecond stamp
   always @(posedge clk_i) cyc <= rst_i ? 0 : cyc + 1;
   edt_top dut (.clk_i(clk_i), .rst_i(rst_i), .first_input_i(first_input_i),
      .second_input_i(second_input_i), .rise_en_i(rise_en_i), .fall_en_i(fall_en_i),
      .large_variant_i(large_variant_i), .system_stop_i(system_stop_i),
      .img_rd_en_i(img_rd_en_i), .img_addr_i(img_addr_i), .img_rd_data_o(img_rd_data_o),
      .img_rd_valid_o(img_rd_valid_o), .out_wr_en_i(out_wr_en_i),
      .out_wr_data_i(out_wr_data_i), .first_input_led_o(first_input_led_o),
      .second_input_led_o(second_input_led_o), .capture_ready_o(capture_ready_o),
      .event_lost_o(event_lost_o), .large_active_o(large_active_o));
   edt_reader rdr (.clk_i(clk_i), .img_rd_data_i(img_rd_data_o),
      .img_rd_valid_i(img_rd_valid_o), .img_rd_en_o(img_rd_en_i), .img_addr_o(img_addr_i));
   // verdict, the single exit of the run
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // compare one flag
   task automatic check_bit(input string name, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask
   // compare one image byte
   task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // change the pins mid-microsecond so the stamp is unambiguous
   task automatic do_edge(input logic a, input logic b);
      logic hit;
      logic [15:0] st;
      while (cyc % 50 != 20) @(negedge clk_i);
      st = 16'(cyc / 50);
      hit = (rise_en_i[0] & a & ~first_input_i) | (fall_en_i[0] & ~a & first_input_i) |
         (rise_en_i[1] & b & ~second_input_i) | (fall_en_i[1] & ~b & second_input_i);
      first_input_i = a;
      second_input_i = b;
      if (hit) begin
         seq_m = (seq_m + 1) % 128;
         img_m[4*slot_m] = {6'h00, b, a};
         img_m[4*slot_m+1] = 8'(seq_m);
         img_m[4*slot_m+2] = st[7:0];
         img_m[4*slot_m+3] = st[15:8];
         slot_m = (slot_m + 1) % nent;
      end
      repeat (10) @(negedge clk_i);
      check_bit("first_led", a, first_input_led_o);
      check_bit("second_led", b, second_input_led_o);
   endtask
   // read the active region plus the first byte beyond it
   task automatic check_image();
      logic [7:0] d;
      logic [7:0] want;
      logic ok;
      for (int a = 0; a <= 4 * nent; a++) begin
         rdr.rd(6'(a), d, ok);
         check_bit("rd_valid", 1'b1, ok);
         want = (a < 4 * nent) ? img_m[a] : 8'h00;
         check_byte($sformatf("image %0d", a), want, d);
      end
   endtask
   // main sequence
   initial begin
      for (int i = 0; i < LARGE_BYTES; i++) img_m[i] = 8'h00;
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      check_bit("event_lost", 1'b0, event_lost_o);
      check_bit("large_active", 1'b0, large_active_o);
      check_image();
      rise_en_i = 2'h1;
      do_edge(1'b1, 1'b0);
      do_edge(1'b0, 1'b0);
      check_image();
      rise_en_i = 2'h3;
      fall_en_i = 2'h2;
      out_wr_en_i = 1'b1; // output image traffic must change nothing
      out_wr_data_i = 8'hff;
      do_edge(1'b1, 1'b1);
      do_edge(1'b1, 1'b0);
      do_edge(1'b0, 1'b0);
      fall_en_i = 2'h3;
      do_edge(1'b1, 1'b0);
      do_edge(1'b0, 1'b0);
      do_edge(1'b1, 1'b1);
      out_wr_en_i = 1'b0;
      check_image();
      // variant changes only while stopped
      system_stop_i = 1'b1;
      large_variant_i = 1'b1;
      repeat (4) @(negedge clk_i);
      system_stop_i = 1'b0;
      nent = LARGE_ENTRIES;
      repeat (2) @(negedge clk_i);
      check_bit("large_active", 1'b1, large_active_o);
      for (int i = 0; i < 124; i++) do_edge(~first_input_i, 1'b1);
      check_image();
      // reads back to back starve the writer until the fifo refuses
      fork
         rdr.burst(200);
         begin
            for (int i = 0; i < 24; i++) begin
               repeat (6) @(negedge clk_i);
               first_input_i = ~first_input_i;
            end
            check_bit("capture_ready", 1'b0, capture_ready_o);
            check_bit("event_lost", 1'b1, event_lost_o);
         end
      join
      repeat (40) @(negedge clk_i);
      check_bit("capture_ready", 1'b1, capture_ready_o);
      check_bit("event_lost", 1'b1, event_lost_o);
      end_sim();
   end
   // hang guard, well past the expected run of about seven thousand cycles
   initial begin
      repeat (30000) @(posedge clk_i);
      errors++;
      $display("Error watchdog expired");
      end_sim();
   end
endmodule // tb_edt_top
`default_nettype wire
